// >>> logic/csp_port.sv
/*
 * Cascaded serial port: link-side capture and launch on the serial clock,
 * daisy-chain handshake, received-byte FIFO, ready chaining and the
 * open-drain alarm and clock-out pins.
 * Assumes the host idles the serial clock high and that pads resolve
 * each output/output-enable pair.
 */
`timescale 1ns/100ps
`include "csp_map.svh"

// ************************************************************
// Received-byte FIFO
// ************************************************************
module csp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `CSP_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } csp_fifo_type;

    csp_fifo_type f_reg;
    csp_fifo_type f_next;
    logic         do_wr;
    logic         do_rd;

    // Honest flags straight from the count
    assign wr_ready = (f_reg.cnt != (AW+1)'(DEPTH));
    assign rd_valid = (f_reg.cnt != '0);
    assign rd_data  = f_reg.mem[f_reg.rp];
    assign do_wr    = wr_valid && wr_ready;
    assign do_rd    = rd_valid && rd_ready;

    // Pointer and count update
    always_comb begin
        f_next = f_reg;
        if (do_wr) begin
            f_next.mem[f_reg.wp] = wr_data;
            f_next.wp            = (f_reg.wp == AW'(DEPTH-1)) ? '0 : f_reg.wp + 1'b1;
        end
        if (do_rd) begin
            f_next.rp = (f_reg.rp == AW'(DEPTH-1)) ? '0 : f_reg.rp + 1'b1;
        end
        f_next.cnt = f_reg.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    c_fifo_full: cover property (@(posedge clk) disable iff (!rstn) !wr_ready);
endmodule

// What this block does
// [R1] Chain input low at a byte's last clock starts our transfer next byte.
// [R2] After our transfer, output floats and input is ignored until new command.
// [R3] Chain input is sampled on every rising serial clock edge.
// [R4] Chain output goes low during the last clock of our last byte.
// [R5] Chain output changes only after a rising serial clock edge.
// [R6] Select falling with chain input low enables serial input and output.
// [R7] Select high ignores input data and floats the serial output.
// [R8] Input bits are captured on falling serial clock edges.
// [R9] Output bits are launched on rising serial clock edges.
// [R10] Host keeps the serial clock high while idle.
// [R11] Output driver also turns on when chain input falls under select low.
// [R12] Output is disabled once the command's byte count has been sent.
// [R13] Overvoltage alarm pulls low while any input is outside the window.
// [R14] Range output pulls low on channel overflow or on the alarm.
// [R15] Clock output buffers the oscillator when crystal enabled, else floats; code also floats it while crystal_fitted is low.
// [R16] Ready output low on new result with ready input low; released otherwise.
// [R17] Bytes are eight bits, MSB first, counted from select falling.
module csp_port #(
    parameter int FRAME_BYTES = `CSP_FRAME_BYTES,
    parameter int FIFO_DEPTH  = `CSP_FIFO_DEPTH
) (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     sclk,
    input  wire logic                     cs_n,
    input  wire logic                     sdi,
    output logic                          sdo_o,
    output logic                          sdo_oe_n,
    input  wire logic                     chain_enable_in_n,
    output logic                          chain_enable_out_n,
    input  wire logic                     ready_chain_in_n,
    output logic                          ready_chain_out_n,
    input  wire logic [8*FRAME_BYTES-1:0] tx_data,
    input  wire logic                     tx_load,
    output logic [7:0]                    rx_data,
    output logic                          rx_valid,
    input  wire logic                     rx_ready,
    output logic                          rx_overrun,
    input  wire logic                     fault_detect,
    input  wire logic                     overflow_detect,
    output logic                          overvoltage_alarm_n_o,
    output logic                          overvoltage_alarm_oe_n,
    output logic                          range_exceed_n_o,
    output logic                          range_exceed_n_oe_n,
    input  wire logic                     osc_input,
    input  wire logic                     crystal_enable_bit,
    input  wire logic                     crystal_fitted,
    output logic                          buffered_osc_out_o,
    output logic                          buffered_osc_out_oe_n
);
    // ************************************************************
    // Declarations
    // ************************************************************
    csp_pkg::csp_rise_type rise_reg;
    csp_pkg::csp_rise_type rise_next;
    csp_pkg::csp_fall_type fall_reg;
    csp_pkg::csp_fall_type fall_next;
    csp_pkg::csp_push_type push_reg;
    csp_pkg::csp_push_type push_next;
    csp_pkg::csp_sys_type  sys_reg;
    csp_pkg::csp_sys_type  sys_next;

    logic                  frame_rst_n;
    logic                  end_of_byte;
    logic                  rx_enabled;
    logic [7:0]            tx_byte;
    logic [31:0]           tx_sel;
    logic                  push_evt;
    logic                  fifo_wr_ready;
    logic                  cs_fall;

    // ************************************************************
    // Link domain: serial clock
    // ************************************************************
    // [R7] Select high clears frame state
    // Select high holds the capture and launch registers in reset, so each frame starts clean
    assign frame_rst_n = rstn && !cs_n;

    // [R17] Byte boundary from select fall
    // Byte ends after the eighth falling edge; this rising edge is its last
    assign end_of_byte = fall_reg.any && (fall_reg.bit_cnt == `CSP_FIRST_BIT);

    // [R2] Input ignored outside command and transfer
    assign rx_enabled = (rise_reg.phase == csp_pkg::ph_cmd) ||
                        (rise_reg.phase == csp_pkg::ph_xfer);

    // Result byte for the next load, MSB byte first
    always_comb begin
        tx_sel  = (rise_reg.phase == csp_pkg::ph_xfer) ? 32'(rise_reg.byte_idx) + 32'h1
                                                       : 32'h0;
        tx_byte = 8'h00;
        if (tx_sel < 32'(FRAME_BYTES)) begin
            tx_byte = sys_reg.result[8*(FRAME_BYTES-1-int'(tx_sel)) +: 8];
        end
    end

    // [R8] Capture on falling edge
    always_comb begin
        fall_next          = fall_reg;
        fall_next.rx_shift = {fall_reg.rx_shift[6:0], sdi};
        fall_next.bit_cnt  = fall_reg.bit_cnt + 3'h1;
        fall_next.any      = 1'b1;
    end

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fall_reg <= '0;
        end else begin
            fall_reg <= fall_next;
        end
    end

    // [R17] Whole byte handed over
    // Toggle survives select high so a frame end never fakes an event
    always_comb begin
        push_next = push_reg;
        if (fall_reg.bit_cnt == `CSP_LAST_BIT && rx_enabled) begin
            push_next.toggle = !push_reg.toggle;
            push_next.hold   = {fall_reg.rx_shift[6:0], sdi};
        end
    end

    always_ff @(negedge sclk or negedge rstn) begin
        if (!rstn) begin
            push_reg <= '0;
        end else begin
            push_reg <= push_next;
        end
    end

    // Rising-edge phase machine
    always_comb begin
        rise_next         = rise_reg;
        // [R3] Chain input sampled
        rise_next.chain_q = chain_enable_in_n;
        unique case (rise_reg.phase)
            csp_pkg::ph_cmd, csp_pkg::ph_wait: begin
                // [R1] Chain low at byte end
                if (end_of_byte && !chain_enable_in_n) begin
                    rise_next.phase      = csp_pkg::ph_xfer;
                    rise_next.byte_idx   = '0;
                    rise_next.bytes_left = `CSP_CNT_W'(FRAME_BYTES);
                    rise_next.sdo        = tx_byte[7];
                    rise_next.tx_shift   = {tx_byte[6:0], 1'b0};
                end else if (end_of_byte) begin
                    rise_next.phase = csp_pkg::ph_wait;
                end
            end
            csp_pkg::ph_xfer: begin
                if (end_of_byte) begin
                    rise_next.chain_out_n = `CSP_CHAIN_IDLE;
                    // [R12] Stop after counted bytes
                    if (rise_reg.bytes_left == `CSP_CNT_W'(1)) begin
                        rise_next.phase = csp_pkg::ph_done;
                        rise_next.sdo   = 1'b0;
                    end else begin
                        rise_next.bytes_left = rise_reg.bytes_left - `CSP_CNT_W'(1);
                        rise_next.byte_idx   = rise_reg.byte_idx + `CSP_CNT_W'(1);
                        rise_next.sdo        = tx_byte[7];
                        rise_next.tx_shift   = {tx_byte[6:0], 1'b0};
                    end
                end else begin
                    // [R9] Launch on rising edge
                    rise_next.sdo      = rise_reg.tx_shift[7];
                    rise_next.tx_shift = {rise_reg.tx_shift[6:0], 1'b0};
                    // [R4] Chain out in last clock
                    if (fall_reg.bit_cnt == `CSP_LAST_BIT &&
                        rise_reg.bytes_left == `CSP_CNT_W'(1)) begin
                        rise_next.chain_out_n = 1'b0;
                    end
                end
            end
            csp_pkg::ph_done: begin
                rise_next.chain_out_n = `CSP_CHAIN_IDLE;
            end
        endcase
    end

    // [R5] Chain output after rising edge
    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rise_reg <= '{phase: csp_pkg::ph_cmd, chain_out_n: `CSP_CHAIN_IDLE, default: '0};
        end else begin
            rise_reg <= rise_next;
        end
    end

    // [R6] Select fall with chain low
    // [R11] Chain fall under select low
    // Pad gating is asynchronous on purpose: the driver must follow the pins
    assign sdo_oe_n = !(!cs_n && rise_reg.phase != csp_pkg::ph_done &&
                        (rise_reg.phase == csp_pkg::ph_xfer || !chain_enable_in_n));
    assign sdo_o              = rise_reg.sdo;
    assign chain_enable_out_n = rise_reg.chain_out_n;

    // ************************************************************
    // System domain: synchronisers, result hold, ready chain
    // ************************************************************
    assign push_evt = sys_reg.tog_s2 ^ sys_reg.tog_s3;
    assign cs_fall  = !sys_reg.cs_s2 && sys_reg.cs_s3;

    always_comb begin
        sys_next        = sys_reg;
        sys_next.cs_s1  = cs_n;
        sys_next.cs_s2  = sys_reg.cs_s1;
        sys_next.cs_s3  = sys_reg.cs_s2;
        sys_next.tog_s1 = push_reg.toggle;
        sys_next.tog_s2 = sys_reg.tog_s1;
        sys_next.tog_s3 = sys_reg.tog_s2;
        sys_next.rdy_s1 = ready_chain_in_n;
        sys_next.rdy_s2 = sys_reg.rdy_s1;
        sys_next.flt_s1 = fault_detect;
        sys_next.flt_s2 = sys_reg.flt_s1;
        sys_next.ovf_s1 = overflow_detect;
        sys_next.ovf_s2 = sys_reg.ovf_s1;
        // Dropped byte when the drain side stalls and the FIFO is full
        sys_next.overrun = push_evt && !fifo_wr_ready;
        // Result stays frozen while a frame may be reading it
        if (sys_reg.load_pend && sys_reg.cs_s2) begin
            sys_next.result    = sys_reg.shadow;
            sys_next.load_pend = 1'b0;
        end
        if (tx_load) begin
            if (sys_reg.cs_s2 && !sys_reg.load_pend) begin
                sys_next.result = $bits(sys_next.result)'(tx_data); // Short frame: low bytes
            end else begin
                sys_next.shadow    = $bits(sys_next.shadow)'(tx_data);
                sys_next.load_pend = 1'b1;
            end
        end
        // [R16] Ready set wins over clear
        if (tx_load) begin
            sys_next.ready_flag = 1'b1;
        end else if (cs_fall) begin
            sys_next.ready_flag = 1'b0;
        end
        sys_next.ready_out_n = sys_reg.rdy_s2 || !sys_next.ready_flag;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, rdy_s1: 1'b1,
                         rdy_s2: 1'b1, ready_out_n: `CSP_READY_IDLE, default: '0};
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign ready_chain_out_n = sys_reg.ready_out_n;
    assign rx_overrun        = sys_reg.overrun;

    csp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rstn     (rstn),
        .wr_valid (push_evt),
        .wr_ready (fifo_wr_ready),
        .wr_data  (push_reg.hold),
        .rd_valid (rx_valid),
        .rd_ready (rx_ready),
        .rd_data  (rx_data)
    );

    // ************************************************************
    // Open-drain indicators and clock out
    // ************************************************************
    // [R13] Alarm pulls the shared wire
    assign overvoltage_alarm_n_o  = 1'b0;
    assign overvoltage_alarm_oe_n = !sys_reg.flt_s2;
    // [R14] Overflow or alarm
    assign range_exceed_n_o       = 1'b0;
    assign range_exceed_n_oe_n    = !(sys_reg.flt_s2 || sys_reg.ovf_s2);
    // [R15] Gated oscillator buffer
    assign buffered_osc_out_o     = osc_input;
    assign buffered_osc_out_oe_n  = !(crystal_enable_bit && crystal_fitted);

    // ************************************************************
    // Assertions
    // ************************************************************
    a_chain_out_last: assert property ( // [R4]
        @(posedge sclk) disable iff (!frame_rst_n)
        !rise_reg.chain_out_n |-> rise_reg.phase == csp_pkg::ph_xfer &&
        rise_reg.bytes_left == `CSP_CNT_W'(1) && end_of_byte)
        else $error("chain output low outside last clock");
    a_xfer_start_chain: assert property ( // [R1]
        @(posedge sclk) disable iff (!frame_rst_n)
        (rise_reg.phase == csp_pkg::ph_xfer && $past(rise_reg.phase) != csp_pkg::ph_xfer)
        |-> !rise_reg.chain_q && $past(end_of_byte))
        else $error("transfer began without chain input low at byte end");
    a_done_floats: assert property ( // [R12]
        @(posedge clk) disable iff (!rstn)
        rise_reg.phase == csp_pkg::ph_done |-> sdo_oe_n)
        else $error("serial output driven after transfer");
    a_cs_high_float: assert property ( // [R7]
        @(posedge clk) disable iff (!rstn)
        cs_n |-> sdo_oe_n && rise_reg.phase == csp_pkg::ph_cmd)
        else $error("output driven or frame alive under select high");
    a_done_no_push: assert property ( // [R2]
        @(negedge sclk) disable iff (!frame_rst_n)
        rise_reg.phase == csp_pkg::ph_done |=> $stable(push_reg.toggle))
        else $error("byte taken after transfer finished");
    a_ready_release: assert property ( // [R16]
        @(posedge clk) disable iff (!rstn)
        sys_reg.rdy_s2 |=> ready_chain_out_n)
        else $error("ready output low with ready input high");
    a_ready_assert: assert property ( // [R16]
        @(posedge clk) disable iff (!rstn)
        tx_load && !sys_reg.rdy_s1 && !sys_reg.rdy_s2 |=> !ready_chain_out_n)
        else $error("new result not flagged on ready output");
    a_alarm_drive: assert property ( // [R13]
        @(posedge clk) disable iff (!rstn)
        fault_detect ##2 1'b1 |-> !overvoltage_alarm_oe_n || !$past(fault_detect, 1))
        else $error("alarm not driven for fault");
    a_range_drive: assert property ( // [R14]
        @(posedge clk) disable iff (!rstn)
        sys_reg.flt_s2 || sys_reg.ovf_s2 |-> !range_exceed_n_oe_n && !range_exceed_n_o)
        else $error("range output not driven");
    a_buffered_osc_out_gate: assert property ( // [R15]
        @(posedge clk) disable iff (!rstn)
        !crystal_enable_bit |-> buffered_osc_out_oe_n)
        else $error("clock output driven with crystal disabled");
    a_push_lands: assert property ( // [R17]
        @(posedge clk) disable iff (!rstn)
        push_evt && fifo_wr_ready |=> rx_valid)
        else $error("received byte did not reach the FIFO");

    c_full_xfer:  cover property (@(posedge sclk) disable iff (!frame_rst_n)
        rise_reg.phase == csp_pkg::ph_done);
    c_chain_wait: cover property (@(posedge sclk) disable iff (!frame_rst_n)
        rise_reg.phase == csp_pkg::ph_wait ##1 rise_reg.phase == csp_pkg::ph_xfer);
    c_overrun:    cover property (@(posedge clk) disable iff (!rstn) rx_overrun);
    c_ready_low:  cover property (@(posedge clk) disable iff (!rstn) !ready_chain_out_n);
endmodule

// >>> include/csp_map.svh
/*
 * Constants of the cascaded serial port: frame sizing, bit positions,
 * FIFO depth and reset values.
 * Assumes it is included by bare name, before any use of its macros.
 */
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH

// ************************************************************
// Frame layout
// ************************************************************
`define CSP_BYTE_BITS      8
`define CSP_FRAME_BYTES    12
`define CSP_CNT_W          8
`define CSP_LAST_BIT       3'h7
`define CSP_FIRST_BIT      3'h0

// ************************************************************
// Buffering and reset values
// ************************************************************
`define CSP_FIFO_DEPTH     16
`define CSP_CHAIN_IDLE     1'b1
`define CSP_READY_IDLE     1'b1

`endif

// >>> include/csp_pkg.sv
/*
 * Types of the cascaded serial port: link phases and state records.
 * Assumes csp_map.svh is reachable on the include path.
 */
`include "csp_map.svh"

package csp_pkg;

    // ************************************************************
    // Link phase within one chip-select frame
    // ************************************************************
    typedef enum logic [1:0] {
        ph_cmd,
        ph_wait,
        ph_xfer,
        ph_done
    } csp_phase_type;

    // ************************************************************
    // State records
    // ************************************************************
    // Rising-edge side of the link (launch, chaining)
    typedef struct packed {
        csp_phase_type              phase;
        logic                       chain_q;
        logic                       chain_out_n;
        logic                       sdo;
        logic [7:0]                 tx_shift;
        logic [`CSP_CNT_W-1:0]      byte_idx;
        logic [`CSP_CNT_W-1:0]      bytes_left;
    } csp_rise_type;

    // Falling-edge side of the link (capture)
    typedef struct packed {
        logic [2:0]                 bit_cnt;
        logic                       any;
        logic [7:0]                 rx_shift;
    } csp_fall_type;

    // Byte handed to the system domain, announced by a toggle
    typedef struct packed {
        logic                       toggle;
        logic [7:0]                 hold;
    } csp_push_type;

    // System clock domain
    typedef struct packed {
        logic                       cs_s1;
        logic                       cs_s2;
        logic                       cs_s3;
        logic                       tog_s1;
        logic                       tog_s2;
        logic                       tog_s3;
        logic                       rdy_s1;
        logic                       rdy_s2;
        logic                       flt_s1;
        logic                       flt_s2;
        logic                       ovf_s1;
        logic                       ovf_s2;
        logic                       ready_flag;
        logic                       ready_out_n;
        logic                       load_pend;
        logic                       overrun;
        logic [8*`CSP_FRAME_BYTES-1:0] result;
        logic [8*`CSP_FRAME_BYTES-1:0] shadow;
    } csp_sys_type;

endpackage

// >>> verif/csp_host.sv
/* Host model of the serial link: drives select, clock and data in.
   Assumes the bench calls one task at a time. */
`timescale 1ns/100ps
module csp_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo_o,
    input  wire logic sdo_oe_n
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            sdi = b[i];
            #12 sclk = 1'b0;
            r[i] = sdo_oe_n ? 1'bz : sdo_o; // Mid period, far from launch
            #24 sclk = 1'b1;
            #12;
        end
    endtask
    task automatic sel(input logic v);
        if (v) sdi = ~sdi; // A released line must not keep the last bit
        cs_n = v;
        #20;
    endtask
endmodule

// >>> verif/testbench.sv
/* Self-checking bench of the cascaded serial port.
   Assumes FRAME_BYTES of 2: each transfer is a command and two bytes. */
`timescale 1ns/100ps
module testbench;
    wire logic   sclk, cs_n, sdi;
    logic        clk = 1'b0, rstn = 1'b0, tx_load = 1'b0, rx_ready = 1'b0, osc_input = 1'b0;
    logic        chain_enable_in_n = 1'b0, ready_chain_in_n = 1'b0, fault_detect = 1'b0;
    logic        overflow_detect = 1'b0, crystal_enable_bit = 1'b0, crystal_fitted = 1'b0;
    logic        sdo_o, sdo_oe_n, chain_enable_out_n, ready_chain_out_n, rx_valid, rx_overrun;
    logic        overvoltage_alarm_n_o, overvoltage_alarm_oe_n, range_exceed_n_o;
    logic        range_exceed_n_oe_n, buffered_osc_out_o, buffered_osc_out_oe_n;
    logic [15:0] tx_data = 16'h0000, ovr_seen = 16'h0000, cout_low = 16'h0000;
    logic [7:0]  rx_data;
    int          err_count = 0, checks_done = 0, cycles = 0;

    csp_port #(.FRAME_BYTES(2), .FIFO_DEPTH(16)) csp_port_inst (.clk, .rstn, .sclk, .cs_n,
        .sdi, .sdo_o, .sdo_oe_n, .chain_enable_in_n, .chain_enable_out_n, .ready_chain_in_n,
        .ready_chain_out_n, .tx_data, .tx_load, .rx_data, .rx_valid, .rx_ready, .rx_overrun,
        .fault_detect, .overflow_detect, .overvoltage_alarm_n_o, .overvoltage_alarm_oe_n,
        .range_exceed_n_o, .range_exceed_n_oe_n, .osc_input, .crystal_enable_bit,
        .crystal_fitted, .buffered_osc_out_o, .buffered_osc_out_oe_n);
    csp_host csp_host_inst (.sclk, .cs_n, .sdi, .sdo_o, .sdo_oe_n);

    // Clocks, event counters and the hang limit
    always #4 clk = ~clk;
    always #20 osc_input = ~osc_input;
    always @(negedge chain_enable_out_n) cout_low = cout_low + 16'h0001;
    always @(negedge clk) begin
        cycles = cycles + 1;
        if (rx_overrun === 1'b1) ovr_seen = ovr_seen + 16'h0001;
        if (cycles == 20000) begin
            err_count++;
            print_verdict;
        end
    end

    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk1(input string w, input logic e, input logic g);
        chk(w, {15'h0000, e}, {15'h0000, g});
    endtask
    // One frame: command, two data bytes, then one byte past the end
    task automatic frame(input logic [7:0] cmd, output logic [15:0] rep);
        logic [7:0] r;
        csp_host_inst.sel(1'b0);
        chk1("oe_select_fall", 1'b0, sdo_oe_n);
        csp_host_inst.xfer(cmd, r);
        csp_host_inst.xfer(8'h3C, rep[15:8]);
        csp_host_inst.xfer(8'h5A, rep[7:0]);
        csp_host_inst.xfer(8'hE7, r);
        chk1("oe_after_xfer", 1'b1, sdo_oe_n);
        csp_host_inst.sel(1'b1);
        repeat (8) @(negedge clk);
    endtask
    task automatic pop(input logic [7:0] e);
        @(negedge clk);
        chk1("rx_valid", 1'b1, rx_valid);
        chk({"rx_data"}, {8'h00, e}, {8'h00, rx_data});
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask
    task automatic t_pins;
        fault_detect = 1'b1;
        repeat (4) @(negedge clk);
        chk1("alarm_on", 1'b0, overvoltage_alarm_oe_n);
        chk1("alarm_level", 1'b0, overvoltage_alarm_n_o);
        chk1("range_by_alarm", 1'b0, range_exceed_n_oe_n);
        chk1("range_level", 1'b0, range_exceed_n_o);
        fault_detect = 1'b0;
        overflow_detect = 1'b1;
        crystal_enable_bit = 1'b1;
        crystal_fitted = 1'b1;
        repeat (4) @(negedge clk);
        chk1("alarm_off", 1'b1, overvoltage_alarm_oe_n);
        chk1("range_by_ovf", 1'b0, range_exceed_n_oe_n);
        chk1("buffered_osc_out_on", 1'b0, buffered_osc_out_oe_n);
        #2 chk1("buffered_osc_out_copy", osc_input, buffered_osc_out_o);
        @(negedge clk);
        overflow_detect = 1'b0;
        crystal_fitted = 1'b0;
        repeat (4) @(negedge clk);
        chk1("range_off", 1'b1, range_exceed_n_oe_n);
        chk1("buffered_osc_out_off", 1'b1, buffered_osc_out_oe_n);
        crystal_fitted = 1'b1;
        crystal_enable_bit = 1'b0;
        @(negedge clk);
        chk1("buffered_osc_out_xtal_off", 1'b1, buffered_osc_out_oe_n);
    endtask
    task automatic t_ready;
        ready_chain_in_n = 1'b1;
        repeat (3) @(negedge clk);
        tx_load = 1'b1;
        @(negedge clk);
        tx_load = 1'b0;
        repeat (2) @(negedge clk);
        chk1("ready_blocked", 1'b1, ready_chain_out_n);
        ready_chain_in_n = 1'b0;
        repeat (3) @(negedge clk);
        chk1("ready_passed", 1'b0, ready_chain_out_n);
    endtask
    task automatic t_xfer;
        logic [15:0] rep;
        tx_data = 16'hA5C3;
        tx_load = 1'b1;
        @(negedge clk);
        tx_load = 1'b0;
        @(negedge clk);
        chk1("ready_low", 1'b0, ready_chain_out_n);
        frame(8'h81, rep);
        chk("reply", 16'hA5C3, rep);
        chk("chain_pulses", 16'h0001, cout_low);
        chk1("ready_released", 1'b1, ready_chain_out_n);
        pop(8'h81);
        pop(8'h3C);
        pop(8'h5A);
        chk1("rx_drained", 1'b0, rx_valid);
    endtask
    task automatic t_chain;
        chain_enable_in_n = 1'b1;
        csp_host_inst.sel(1'b0);
        chk1("oe_chain_high", 1'b1, sdo_oe_n);
        @(negedge clk);
        chain_enable_in_n = 1'b0;
        @(negedge clk);
        chk1("oe_chain_fall", 1'b0, sdo_oe_n);
        csp_host_inst.sel(1'b1);
        chk1("oe_select_high", 1'b1, sdo_oe_n);
    endtask
    // Neighbour owns the first byte after the command: we wait, then answer
    task automatic t_wait;
        logic [7:0] a, b;
        chain_enable_in_n = 1'b1;
        csp_host_inst.sel(1'b0);
        csp_host_inst.xfer(8'h42, a);
        chain_enable_in_n = 1'b0;
        csp_host_inst.xfer(8'h99, a);
        csp_host_inst.xfer(8'h3C, a);
        csp_host_inst.xfer(8'h5A, b);
        chk("wait_reply", 16'hA5C3, {a, b});
        chk("wait_chain", 16'h0002, cout_low);
        csp_host_inst.sel(1'b1);
        repeat (8) @(negedge clk);
        pop(8'h42);
        pop(8'h3C);
        pop(8'h5A);
        chk1("wait_skipped", 1'b0, rx_valid);
    endtask
    // Eighteen bytes into sixteen slots while the drain stalls
    task automatic t_fill;
        logic [15:0] rep, base;
        base = ovr_seen;
        repeat (6) frame(8'h42, rep);
        chk("overruns", 16'h0002, ovr_seen - base);
        for (int i = 0; i < 16; i++) pop(i % 3 == 0 ? 8'h42 : i % 3 == 1 ? 8'h3C : 8'h5A);
        chk1("fifo_empty", 1'b0, rx_valid);
    endtask
    task automatic print_verdict;
        $display("Mismatches %0d of %0d checks", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_pins;
        t_ready;
        t_xfer;
        t_chain;
        t_wait;
        t_fill;
        print_verdict;
    end
endmodule
